//--- core/vpi_ctrl.v
`timescale 1ns/100ps
`include "vpi_regs.vh"

module vpi_ctrl
(
  input  wire        core_clk_i,
  input  wire        rstn_i,
  input  wire [3:0]  req_line_i,
  input  wire        multi_line_i,
  output reg  [3:0]  grant_o,
  input  wire        vec_valid_i,
  input  wire [15:0] vec_i,
  input  wire        dma_req_i,
  output reg         dma_grant_o,
  input  wire        pwr_fail_i,
  input  wire        insn_boundary_i,
  input  wire        rti_i,
  input  wire        pc_wr_i,
  input  wire [15:0] pc_i,
  input  wire        psw_wr_i,
  input  wire [15:0] psw_i,
  input  wire        sp_wr_i,
  input  wire [15:0] sp_i,
  output wire [15:0] program_counter_o,
  output wire [15:0] processor_status_word_o,
  output wire [15:0] sp_o,
  output wire        busy_o,
  output wire        mem_req_o,
  output wire        mem_we_o,
  output reg  [15:0] mem_addr_o,
  output reg  [15:0] mem_wdata_o,
  input  wire        mem_ack_i,
  input  wire [15:0] mem_rdata_i
);

  localparam [8:0] ST_IDLE      = 9'h001;
  localparam [8:0] ST_GRANT     = 9'h002;
  localparam [8:0] ST_PUSH_PC   = 9'h004;
  localparam [8:0] ST_PUSH_PSW  = 9'h008;
  localparam [8:0] ST_FETCH_PC  = 9'h010;
  localparam [8:0] ST_FETCH_PSW = 9'h020;
  localparam [8:0] ST_POP_PSW   = 9'h040;
  localparam [8:0] ST_POP_PC    = 9'h080;
  localparam [8:0] ST_DMA       = 9'h100;
  reg  [8:0]  state;
  reg  [15:0] program_counter;
  reg  [15:0] processor_status_word;
  reg  [15:0] sp;
  reg  [15:0] vec;
  reg         pend_any;
  reg  [2:0]  pend_lvl;
  reg  [3:0]  pend_onehot;
  reg         pf_prev;
  reg         pf_pend;
  reg         rs_pend;
  reg  [3:0]  eff_req;
  reg         next_any;
  reg  [2:0]  next_lvl;
  reg  [3:0]  next_onehot;
  integer     i;
  wire [2:0]  cpu_lvl;
  wire        accept;
  wire        pf_rise;
  wire        pf_fall;
  wire        take_pf;
  wire        take_rs;
  assign program_counter_o       = program_counter;
  assign processor_status_word_o = processor_status_word;
  assign sp_o                    = sp;
  assign busy_o                  = (state != ST_IDLE);
  assign mem_req_o = (state == ST_PUSH_PC) | (state == ST_PUSH_PSW) |
                     (state == ST_FETCH_PC) | (state == ST_FETCH_PSW) |
                     (state == ST_POP_PSW) | (state == ST_POP_PC);
  assign mem_we_o  = (state == ST_PUSH_PC) | (state == ST_PUSH_PSW);
  assign cpu_lvl = processor_status_word[`VPI_PSW_PRI_MSB:`VPI_PSW_PRI_LSB];
  // line option, fixed level per line, highest wins
  always @*
  begin
    eff_req     = multi_line_i ? req_line_i : {3'h0, req_line_i[0]};
    next_any    = 1'b0;
    next_lvl    = 3'h0;
    next_onehot = 4'h0;
    for (i = 0; i < `VPI_NUM_LINES; i = i + 1)
    begin
      if (eff_req[i])
      begin
        next_any    = 1'b1;
        next_lvl    = `VPI_LVL_BASE + {1'b0, i[1:0]};
        next_onehot = 4'h1 << i[1:0];
      end
    end
  end

  // strictly above, preemption follows from loaded level
  assign accept = pend_any && (pend_lvl > cpu_lvl);
  assign pf_rise = pwr_fail_i & ~pf_prev;
  assign pf_fall = ~pwr_fail_i & pf_prev;
  assign take_pf = (state == ST_IDLE) & ~dma_req_i & insn_boundary_i &
                   pf_pend;
  assign take_rs = (state == ST_IDLE) & ~dma_req_i & insn_boundary_i &
                   ~pf_pend & rs_pend;

  // sampled every cycle, independent of sequencer
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pend_any    <= 1'b0;
      pend_lvl    <= 3'h0;
      pend_onehot <= 4'h0;
      pf_prev     <= 1'b0;
      pf_pend     <= 1'b0;
      rs_pend     <= 1'b0;
    end
    else
    begin
      pend_any    <= next_any;
      pend_lvl    <= next_lvl;
      pend_onehot <= next_onehot;
      // power events, set wins over clear
      pf_prev     <= pwr_fail_i;
      pf_pend     <= (pf_pend & ~take_pf) | pf_rise;
      rs_pend     <= (rs_pend & ~take_rs) | pf_fall;
    end
  end

  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state                 <= ST_IDLE;
      program_counter       <= `VPI_PC_RST;
      processor_status_word <= `VPI_PSW_RST;
      sp                    <= `VPI_SP_RST;
      vec                   <= 16'h0000;
      grant_o               <= 4'h0;
      dma_grant_o           <= 1'b0;
      mem_addr_o            <= 16'h0000;
      mem_wdata_o           <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (pc_wr_i)
            program_counter <= pc_i;
          if (psw_wr_i)
            processor_status_word <= psw_i;
          if (sp_wr_i)
            sp <= sp_i;
          if (dma_req_i)
          begin
            dma_grant_o <= 1'b1;
            state       <= ST_DMA;
          end
          else if (insn_boundary_i)
          begin
            if (pf_pend)
            begin
              vec         <= `VPI_PWRFAIL_VEC;
              mem_addr_o  <= sp - `VPI_WORD_STEP;
              mem_wdata_o <= program_counter;
              state       <= ST_PUSH_PC;
            end
            else if (rs_pend)
            begin
              vec        <= `VPI_RESTART_VEC;
              mem_addr_o <= `VPI_RESTART_VEC;
              state      <= ST_FETCH_PC;
            end
            else if (rti_i)
            begin
              mem_addr_o <= sp;
              state      <= ST_POP_PSW;
            end
            else if (accept)
            begin
              grant_o <= pend_onehot;
              state   <= ST_GRANT;
            end
          end
        end
        ST_GRANT:
        begin
          if (vec_valid_i)
          begin
            grant_o     <= 4'h0;
            vec         <= vec_i;
            mem_addr_o  <= sp - `VPI_WORD_STEP;
            mem_wdata_o <= program_counter;
            state       <= ST_PUSH_PC;
          end
          else if ((grant_o & eff_req) == 4'h0)
          begin
            grant_o <= 4'h0;
            state   <= ST_IDLE;
          end
        end
        ST_PUSH_PC:
        begin
          if (mem_ack_i)
          begin
            sp          <= mem_addr_o;
            mem_addr_o  <= mem_addr_o - `VPI_WORD_STEP;
            mem_wdata_o <= processor_status_word;
            state       <= ST_PUSH_PSW;
          end
        end
        ST_PUSH_PSW:
        begin
          if (mem_ack_i)
          begin
            sp         <= mem_addr_o;
            mem_addr_o <= vec;
            state      <= ST_FETCH_PC;
          end
        end
        // load new counter and status from vector entry
        ST_FETCH_PC:
        begin
          if (mem_ack_i)
          begin
            program_counter <= mem_rdata_i;
            mem_addr_o      <= vec + `VPI_WORD_STEP;
            state           <= ST_FETCH_PSW;
          end
        end
        ST_FETCH_PSW:
        begin
          if (mem_ack_i)
          begin
            processor_status_word <= mem_rdata_i;
            state                 <= ST_IDLE;
          end
        end
        // restored level resumes the preempted handler
        ST_POP_PSW:
        begin
          if (mem_ack_i)
          begin
            processor_status_word <= mem_rdata_i;
            mem_addr_o            <= mem_addr_o + `VPI_WORD_STEP;
            state                 <= ST_POP_PC;
          end
        end
        ST_POP_PC:
        begin
          if (mem_ack_i)
          begin
            program_counter <= mem_rdata_i;
            sp              <= mem_addr_o + `VPI_WORD_STEP;
            state           <= ST_IDLE;
          end
        end
        // hold grant while the transfer runs
        ST_DMA:
        begin
          if (!dma_req_i)
          begin
            dma_grant_o <= 1'b0;
            state       <= ST_IDLE;
          end
        end
        default:
        begin
          grant_o     <= 4'h0;
          dma_grant_o <= 1'b0;
          state       <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // vpi_ctrl

//--- core/vpi_regs.vh
`ifndef VPI_REGS_VH
`define VPI_REGS_VH

// Processor status word priority field
`define VPI_PSW_PRI_LSB      5
`define VPI_PSW_PRI_MSB      7
`define VPI_PSW_RST          16'h0000
`define VPI_PC_RST           16'h0000
`define VPI_SP_RST           16'h0000

// Request lines 0..3 request at levels 4..7
`define VPI_NUM_LINES        4
`define VPI_LVL_BASE         3'h4

// Fixed vector entries for power events
`define VPI_PWRFAIL_VEC      16'h0024
`define VPI_RESTART_VEC      16'h0024

// Words are two bytes apart
`define VPI_WORD_STEP        16'h0002

`endif

//--- dv/vectored_priority_interrupt_bench.sv
`timescale 1ns/100ps
module vectored_priority_interrupt_bench;
  logic core_clk_i = 0, rstn_i = 0, multi_line_i = 1, dma_req_i = 0;
  logic pwr_fail_i = 0, insn_boundary_i = 0, rti_i = 0, slow_i = 0;
  logic pc_wr_i = 0, psw_wr_i = 0, sp_wr_i = 0;
  logic [15:0] pc_i = 0, psw_i = 0, sp_i = 0, vec_i, mem_rdata_i, sp_o;
  logic [3:0] raise_i = 0, drop_i = 0, req_line_i, grant_o;
  logic vec_valid_i, mem_ack_i, dma_grant_o, busy_o, mem_req_o, mem_we_o;
  logic [15:0] mem_addr_o, mem_wdata_o, program_counter_o;
  logic [15:0] processor_status_word_o;
  int error_cnt = 0, n_tests = 0;
  vpi_ctrl uut (.*);
  vpi_dev_model dev (.*);
  initial
  begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  task complete_run;
    $display("mismatches %0d of %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task st(input logic [15:0] pc, psw, sp);
    chk(program_counter_o, pc);
    chk(processor_status_word_o, psw);
    chk(sp_o, sp);
  endtask
  task setc(input logic [15:0] pc, psw, sp);
    {pc_i, psw_i, sp_i} = {pc, psw, sp};
    {pc_wr_i, psw_wr_i, sp_wr_i} = 3'h7;
    cyc(1);
    {pc_wr_i, psw_wr_i, sp_wr_i} = 3'h0;
  endtask
  task rq(input logic [3:0] m);
    raise_i = m;
    cyc(1);
    raise_i = 0;
  endtask
  // Instruction boundary, then wait for the sequencer to settle
  task bnd(input logic r);
    int i;
    cyc(2);
    {insn_boundary_i, rti_i} = {1'b1, r};
    cyc(1);
    {insn_boundary_i, rti_i} = 2'h0;
    cyc(1);
    for (i = 0; i < 300 && busy_o !== 1'b0; i++)
      cyc(1);
    if (i == 300)
    begin
      error_cnt++;
      complete_run;
    end
  endtask
  task t_refuse;
    setc(16'h0400, 16'h00A0, 16'h01F0);
    rq(4'h2);
    bnd(0);
    st(16'h0400, 16'h00A0, 16'h01F0);
  endtask
  task t_nest;
    setc(16'h0400, 16'h0000, 16'h01F0);
    bnd(0);
    st(16'h1100, 16'h0061, 16'h01EC);
    chk(dev.mem[8'hF7], 16'h0400);
    chk(dev.mem[8'hF6], 16'h0000);
    slow_i = 1;
    rq(4'hC);
    bnd(0);
    st(16'h1300, 16'h0063, 16'h01E8);
    bnd(1);
    st(16'h1100, 16'h0061, 16'h01EC);
    bnd(0);
    st(16'h1200, 16'h0062, 16'h01E8);
    slow_i = 0;
    bnd(1);
    bnd(1);
    st(16'h0400, 16'h0000, 16'h01F0);
  endtask
  task t_dma;
    dma_req_i = 1;
    cyc(2);
    chk({15'h0, dma_grant_o}, 16'h0001);
    rq(4'h8);
    cyc(3);
    chk({11'h0, busy_o, grant_o}, 16'h0010);
    dma_req_i = 0;
    cyc(2);
    chk({15'h0, dma_grant_o}, 16'h0000);
    bnd(0);
    st(16'h1300, 16'h0063, 16'h01EC);
    bnd(1);
  endtask
  task t_pwr;
    pwr_fail_i = 1;
    bnd(0);
    st(16'h2000, 16'h00E0, 16'h01EC);
    chk(dev.mem[8'hF7], 16'h0400);
    setc(16'h0500, 16'h0000, 16'h01F0);
    pwr_fail_i = 0;
    bnd(0);
    st(16'h2000, 16'h00E0, 16'h01F0);
  endtask
  task t_single;
    multi_line_i = 0;
    setc(16'h0600, 16'h0000, 16'h01F0);
    rq(4'h4);
    bnd(0);
    st(16'h0600, 16'h0000, 16'h01F0);
    rq(4'h1);
    bnd(0);
    st(16'h1000, 16'h0060, 16'h01EC);
  endtask
  // Request withdrawn while granted, before the vector comes
  task t_drop;
    slow_i = 1;
    rq(4'h1);
    cyc(2);
    insn_boundary_i = 1;
    cyc(1);
    {insn_boundary_i, drop_i} = {1'b0, 4'h1};
    cyc(1);
    drop_i = 4'h0;
    cyc(1);
    chk({11'h0, busy_o, grant_o}, 16'h0000);
    bnd(0);
    st(16'h1000, 16'h0060, 16'h01EC);
    slow_i = 0;
  endtask
  initial
  begin
    cyc(10);
    rstn_i = 1;
    st(16'h0000, 16'h0000, 16'h0000);
    t_refuse;
    t_nest;
    t_dma;
    t_pwr;
    t_single;
    t_drop;
    complete_run;
  end
endmodule // vectored_priority_interrupt_bench

//--- dv/vpi_ctrl_sva.sv
`timescale 1ns/100ps
module vpi_ctrl_sva
(
  input logic        core_clk_i,
  input logic        rstn_i,
  input logic [3:0]  grant_o,
  input logic [15:0] processor_status_word_o,
  input logic        multi_line_i,
  input logic        insn_boundary_i,
  input logic        busy_o,
  input logic        dma_req_i,
  input logic        dma_grant_o,
  input logic        mem_req_o,
  input logic        mem_ack_i,
  input logic [15:0] mem_addr_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic [2:0] lvl;
  assign lvl = grant_o[3] ? 3'h7 : grant_o[2] ? 3'h6 :
               grant_o[1] ? 3'h5 : 3'h4;
  property p_onehot;
    |grant_o |-> $onehot(grant_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("grant not one-hot");
  property p_above;
    $rose(|grant_o) |-> lvl > processor_status_word_o[7:5];
  endproperty
  a_above: assert property (p_above) else $error("grant not above");
  property p_single;
    $rose(|grant_o) && !multi_line_i |-> grant_o == 4'h1;
  endproperty
  a_single: assert property (p_single) else $error("single line");
  property p_bound;
    $rose(|grant_o) |-> $past(insn_boundary_i);
  endproperty
  a_bound: assert property (p_bound) else $error("no boundary");
  property p_dma_take;
    !busy_o && dma_req_i |=> dma_grant_o;
  endproperty
  a_dma_take: assert property (p_dma_take) else $error("dma take");
  property p_dma_drop;
    dma_grant_o && !dma_req_i |=> !dma_grant_o;
  endproperty
  a_dma_drop: assert property (p_dma_drop) else $error("dma drop");
  property p_dma_excl;
    dma_grant_o |-> !mem_req_o && grant_o == 4'h0;
  endproperty
  a_dma_excl: assert property (p_dma_excl) else $error("dma excl");
  property p_mem_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("mem hold");
  property p_gbusy;
    |grant_o |-> busy_o;
  endproperty
  a_gbusy: assert property (p_gbusy) else $error("grant idle");
endmodule // vpi_ctrl_sva
bind vpi_ctrl vpi_ctrl_sva chk
(
  .core_clk_i              (core_clk_i),
  .rstn_i                  (rstn_i),
  .grant_o                 (grant_o),
  .processor_status_word_o (processor_status_word_o),
  .multi_line_i            (multi_line_i),
  .insn_boundary_i         (insn_boundary_i),
  .busy_o                  (busy_o),
  .dma_req_i               (dma_req_i),
  .dma_grant_o             (dma_grant_o),
  .mem_req_o               (mem_req_o),
  .mem_ack_i               (mem_ack_i),
  .mem_addr_o              (mem_addr_o)
);

//--- dv/vpi_dev_model.sv
`timescale 1ns/100ps
module vpi_dev_model
(
  input  logic        core_clk_i,
  input  logic        rstn_i,
  input  logic [3:0]  raise_i,
  input  logic [3:0]  drop_i,
  input  logic        slow_i,
  input  logic [3:0]  grant_o,
  input  logic        mem_req_o,
  input  logic        mem_we_o,
  input  logic [15:0] mem_addr_o,
  input  logic [15:0] mem_wdata_o,
  output logic [3:0]  req_line_i,
  output logic        vec_valid_i,
  output logic [15:0] vec_i,
  output logic        mem_ack_i,
  output logic [15:0] mem_rdata_i
);
  logic [15:0] mem [0:255];
  logic [1:0]  wt;
  logic [1:0]  mc;
  logic [1:0]  idx;
  logic        ack;
  assign idx = grant_o[3] ? 2'h3 : grant_o[2] ? 2'h2 : {1'b0, grant_o[1]};
  assign ack = mem_req_o && !mem_ack_i && mc == {slow_i, 1'b0};
  initial
  begin
    for (int k = 0; k < 4; k++)
    begin
      mem[8'h80 + 4 * k] = 16'h1000 + 16'h0100 * k;
      mem[8'h81 + 4 * k] = 16'h0060 + k;
    end
    mem[8'h12] = 16'h2000;
    mem[8'h13] = 16'h00E0;
  end
  always @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      {req_line_i, vec_valid_i, wt, mc, mem_ack_i} <= '0;
      {vec_i, mem_rdata_i} <= {2{16'hA5C3}};
    end
    else
    begin
      req_line_i <= (req_line_i | raise_i) & ~drop_i &
                    ~(vec_valid_i ? grant_o : 4'h0);
      wt <= (|grant_o && !vec_valid_i) ? wt + 2'h1 : 2'h0;
      vec_valid_i <= |grant_o && !vec_valid_i && wt == {slow_i, 1'b0};
      vec_i <= |grant_o ? 16'h0100 + {idx, 3'h0} : ~vec_i;
      mc <= (mem_req_o && !mem_ack_i) ? mc + 2'h1 : 2'h0;
      mem_ack_i <= ack;
      mem_rdata_i <= ack ? mem[mem_addr_o[8:1]] : ~mem_rdata_i;
      if (mem_req_o && mem_ack_i && mem_we_o)
        mem[mem_addr_o[8:1]] <= mem_wdata_o;
    end
endmodule // vpi_dev_model
